// ---- core/tsrl_map.svh ----
// Register map and timing constants of the test sequencer and result logger.
// Included by the timer, log and top design files; holds definitions only.
`ifndef TSRL_MAP_SVH
`define TSRL_MAP_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TSRL_A_CMD 8'h00
`define TSRL_A_STATUS 8'h04
`define TSRL_A_PROG 8'h08
`define TSRL_A_TNUM 8'h0c
`define TSRL_A_FLOW 8'h10
`define TSRL_A_ERRS 8'h14
`define TSRL_A_DUR 8'h18
`define TSRL_A_CFG 8'h1c
`define TSRL_A_IVL 8'h20
`define TSRL_A_TIME 8'h24
`define TSRL_A_LABEL 8'h28
`define TSRL_A_LSEL 8'h2c
`define TSRL_A_LCNT 8'h30
`define TSRL_A_LDATA 8'h34
// ****************************************************************
// Command bits and field positions
// ****************************************************************
`define TSRL_C_START 0
`define TSRL_C_STOP 1
`define TSRL_C_APPLY 2
`define TSRL_C_COMMIT 3
`define TSRL_C_ERASE 4
`define TSRL_C_DLALL 5
`define TSRL_C_DLNEW 6
`define TSRL_F_CONT 0
`define TSRL_F_SIM 1
`define TSRL_F_FMT 3:2
`define TSRL_F_TGT 15:8
// ****************************************************************
// Sizes, reset values and timing
// ****************************************************************
`define TSRL_CLK_HZ 10000000
`define TSRL_TICK_S 1
`define TSRL_TICK_CYC (`TSRL_CLK_HZ * `TSRL_TICK_S)
`define TSRL_DUR_MIN 2
`define TSRL_DUR_RST (`TSRL_DUR_MIN * 60)
`define TSRL_PROG_MAX 1000
`define TSRL_LOG_DEPTH 4000
`define TSRL_LABEL_LEN 15
`endif

// ---- core/tsrl_pkg.sv ----
// Types shared by the test sequencer and result logger.
// Assumes nothing of its surroundings.
package tsrl_pkg;
  // Test sequencer states.
  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_TEST = 2'b01,
    ST_WAIT = 2'b10
  } tsrl_state_t;
  // Log walk states.
  typedef enum logic [1:0] {
    LG_IDLE = 2'b00,
    LG_SEEK = 2'b01,
    LG_SHOW = 2'b10
  } tsrl_lstate_t;
endpackage : tsrl_pkg

// ---- core/tsrl_timer.sv ----
// Second tick prescaler and time-of-day counter in seconds.
// Assumes one system clock; the load comes from logic on that clock.
`timescale 1ns/100ps
`include "tsrl_map.svh"
module tsrl_timer #(
  parameter int TICK_CYCLES = `TSRL_TICK_CYC
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_reset_n, // Synchronous reset, active low.
  input wire logic i_load, // Load the time of day.
  input wire logic [31:0] i_load_val, // Time to load.
  output logic o_sec_tick, // One-cycle pulse each second.
  output logic [31:0] o_time // Time of day in seconds.
);
  localparam int CW = $clog2(TICK_CYCLES);
  if (TICK_CYCLES < 2) begin : g_bad
    $error("TICK_CYCLES must be at least 2.");
  end
  logic [CW-1:0] pre;
  wire wrap = (pre == CW'(TICK_CYCLES - 1));
  // Prescaler, tick and time of day; a load restarts the second.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pre <= '0;
      o_sec_tick <= 1'b0;
      o_time <= 32'h0;
    end else begin
      pre <= (wrap || i_load) ? '0 : pre + 1'b1;
      o_sec_tick <= wrap && !i_load;
      o_time <= i_load ? i_load_val : o_time + {31'h0, wrap};
    end
  end
endmodule : tsrl_timer

// ---- core/tsrl_log.sv ----
// Circular result log with a per-record downloaded flag.
// Assumes pushes, erases and walk requests come from the same clock.
`timescale 1ns/100ps
`include "tsrl_map.svh"
module tsrl_log #(
  parameter int DEPTH = `TSRL_LOG_DEPTH,
  parameter int W = 80
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_reset_n, // Synchronous reset, active low.
  input wire logic i_push, // Store one record.
  input wire logic [W-1:0] i_rec, // Record to store.
  input wire logic i_erase, // Empty the log.
  input wire logic i_start, // Begin a walk from the oldest record.
  input wire logic i_new_only, // Walk skips downloaded records.
  input wire logic i_next, // Current record taken.
  output logic [W-1:0] o_rec, // Current record.
  output logic o_valid, // Current record stands.
  output logic [15:0] o_count // Records held.
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || DEPTH > 65535) begin : g_bad
    $error("DEPTH out of range.");
  end
  logic [W-1:0] mem [DEPTH];
  logic [DEPTH-1:0] dl;
  logic [AW-1:0] wp, rp;
  logic [15:0] left;
  tsrl_pkg::tsrl_lstate_t st;
  wire [AW-1:0] wp_inc = (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
  wire [AW-1:0] rp_inc = (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
  wire [AW-1:0] cnt_a = AW'(o_count);
  wire [AW-1:0] oldest = (wp >= cnt_a) ? wp - cnt_a : AW'(DEPTH) - cnt_a + wp;
  // A push in the cycle of an erase survives, stored at the start.
  wire [AW-1:0] wr_at = i_erase ? '0 : wp;
  assign o_valid = (st == tsrl_pkg::LG_SHOW);
  // Storage; a full log overwrites its oldest record.
  always_ff @(posedge i_sys_clk) begin
    o_rec <= mem[rp];
    if (i_push) begin
      mem[wr_at] <= i_rec;
    end
  end
  // Pointers, count, flags and walk.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || i_erase) begin
      wp <= (i_reset_n && i_push) ? AW'(1) : '0;
      rp <= '0;
      o_count <= {15'h0, i_reset_n && i_push};
      left <= 16'h0;
      dl <= '0;
      st <= tsrl_pkg::LG_IDLE;
    end else begin
      if (i_push) begin
        dl[wp] <= 1'b0;
        wp <= wp_inc;
        o_count <= (o_count == 16'(DEPTH)) ? o_count : o_count + 16'h1;
      end
      case (st)
        tsrl_pkg::LG_IDLE: begin
          if (i_start) begin
            rp <= oldest;
            left <= o_count;
            st <= tsrl_pkg::LG_SEEK;
          end
        end
        tsrl_pkg::LG_SEEK: begin
          if (left == 16'h0) begin
            st <= tsrl_pkg::LG_IDLE;
          end else if (i_new_only && dl[rp]) begin
            rp <= rp_inc;
            left <= left - 16'h1;
          end else begin
            st <= tsrl_pkg::LG_SHOW;
          end
        end
        default: begin
          if (i_next) begin
            dl[rp] <= 1'b1;
            rp <= rp_inc;
            left <= left - 16'h1;
            st <= tsrl_pkg::LG_SEEK;
          end
        end
      endcase
    end
  end
endmodule : tsrl_log

// ---- core/tsrl_top.sv ----
// Test sequencer and result logger: runs, abandons and repeats tests,
// reports progress, flow and status, and keeps a circular result log.
// Assumes a host register port on the same clock; error pulses, flow
// rate and result come from same-clock logic; flow presence is a pin.
`timescale 1ns/100ps
`include "tsrl_map.svh"
module tsrl_top #(
  parameter int TICK_CYCLES = `TSRL_TICK_CYC, // Cycles per second tick.
  parameter int LOG_DEPTH = `TSRL_LOG_DEPTH, // Records held.
  parameter logic [31:0] SERIAL_NUM = 32'h0000_0001 // Arbitrary value.
) (
  input wire logic i_sys_clk, // System clock, 10 MHz.
  input wire logic i_reset_n, // Synchronous reset, active low.
  input wire logic [7:0] i_addr, // Register byte address.
  input wire logic [31:0] i_wdata, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [31:0] o_rdata, // Read data, cycle after strobe.
  input wire logic i_flow_present, // Flow seen at the cell, pin.
  input wire logic [15:0] i_flow_rate, // Measured flow, ml/min.
  input wire logic [31:0] i_result, // Four cleanliness codes.
  input wire logic i_ext_err, // External link error pulse.
  input wire logic i_int_err, // Internal link error pulse.
  output logic o_testing, // A test is running.
  output logic o_alarm, // Result above target.
  output logic o_fault // Low-flow fault.
);
  localparam int LL = `TSRL_LABEL_LEN;
  if (LOG_DEPTH < 2 || TICK_CYCLES < 2) begin : g_bad
    $error("LOG_DEPTH and TICK_CYCLES must be at least 2.");
  end
  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Write decode and command pulses.
  wire wr_cmd = i_wr && (i_addr == `TSRL_A_CMD);
  wire c_start = wr_cmd && i_wdata[`TSRL_C_START];
  wire c_stop = wr_cmd && i_wdata[`TSRL_C_STOP];
  wire c_apply = wr_cmd && i_wdata[`TSRL_C_APPLY];
  wire c_commit = wr_cmd && i_wdata[`TSRL_C_COMMIT];
  wire c_erase = wr_cmd && i_wdata[`TSRL_C_ERASE];
  wire c_dlall = wr_cmd && i_wdata[`TSRL_C_DLALL];
  wire c_dlnew = wr_cmd && i_wdata[`TSRL_C_DLNEW];
  wire wr_errs = i_wr && (i_addr == `TSRL_A_ERRS);
  wire wr_time = i_wr && (i_addr == `TSRL_A_TIME);
  wire wr_label = i_wr && (i_addr == `TSRL_A_LABEL);
  wire rd_ldata = i_rd && (i_addr == `TSRL_A_LDATA);
  // ****************************************************************
  // State
  // ****************************************************************
  tsrl_pkg::tsrl_state_t state;
  logic [9:0] prog;
  logic [17:0] acc;
  logic [15:0] el_s, tnum, flow, ext_cnt, int_cnt;
  logic [15:0] dur, ivl, p_dur, p_ivl, cfg, p_cfg;
  logic [7:0] stage [LL];
  logic [7:0] label [LL];
  logic [3:0] lsel;
  logic [1:0] word;
  logic fault, flow_m, flow_s, dl_new;
  logic [31:0] tod, next_rdata;
  logic sec_tick, log_valid;
  logic [79:0] log_rec;
  logic [15:0] log_cnt;
  // Second tick and time of day.
  tsrl_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_load(wr_time),
    .i_load_val(i_wdata),
    .o_sec_tick(sec_tick),
    .o_time(tod)
  );
  // ****************************************************************
  // Test sequencing
  // ****************************************************************
  // Progress accumulates 1000 per second and steps each time the accumulator reaches the duration.
  wire [17:0] acc_add = acc + (sec_tick ? 18'h3e8 : 18'h0);
  wire prog_step = (acc_add >= {2'b00, dur}) && (prog < 10'(`TSRL_PROG_MAX));
  wire [15:0] el_inc = el_s + {15'h0, sec_tick};
  wire [15:0] next_tnum = tnum + 16'h1;
  wire done = (state == tsrl_pkg::ST_TEST) && (el_s >= dur);
  wire wait_end = (state == tsrl_pkg::ST_WAIT) && (el_s >= ivl);
  wire repeat_now = cfg[`TSRL_F_CONT] && (ivl <= el_s);
  wire begin_test = (c_start && !c_stop) || wait_end || (done && repeat_now);
  wire low_flow = !flow_s && !cfg[`TSRL_F_SIM];
  wire [7:0] code = i_result[8*cfg[`TSRL_F_FMT] +: 8];
  // Flow presence pin synchroniser.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      flow_m <= 1'b0;
      flow_s <= 1'b0;
    end else begin
      flow_m <= i_flow_present;
      flow_s <= flow_m;
    end
  end
  // Sequencer state machine.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state <= tsrl_pkg::ST_READY;
    end else if (c_stop) begin
      state <= tsrl_pkg::ST_READY;
    end else if (begin_test) begin
      state <= tsrl_pkg::ST_TEST;
    end else begin
      case (state)
        tsrl_pkg::ST_TEST: begin
          if (done) begin
            state <= cfg[`TSRL_F_CONT] ? tsrl_pkg::ST_WAIT : tsrl_pkg::ST_READY;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end
  // Progress, elapsed seconds and per-test results.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      prog <= 10'h0;
      acc <= 18'h0;
      el_s <= 16'h0;
      tnum <= 16'h0;
      flow <= 16'h0;
      fault <= 1'b0;
      o_alarm <= 1'b0;
    end else begin
      if (begin_test) begin
        prog <= 10'h0;
        acc <= 18'h0;
      end else if (state == tsrl_pkg::ST_TEST) begin
        prog <= done ? 10'(`TSRL_PROG_MAX) : prog + {9'h0, prog_step};
        acc <= prog_step ? acc_add - {2'b00, dur} : acc_add;
      end
      if (begin_test || c_stop) begin
        el_s <= 16'h0;
      end else if (state != tsrl_pkg::ST_READY) begin
        el_s <= el_inc;
      end
      if (done) begin
        tnum <= next_tnum;
        flow <= i_flow_rate;
        fault <= low_flow;
        o_alarm <= code > cfg[`TSRL_F_TGT];
      end
    end
  end
  // ****************************************************************
  // Settings, label and error tallies
  // ****************************************************************
  // Staged settings become active only on commit.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      dur <= 16'(`TSRL_DUR_RST);
      p_dur <= 16'(`TSRL_DUR_RST);
      ivl <= 16'h0;
      p_ivl <= 16'h0;
      cfg <= 16'h0;
      p_cfg <= 16'h0;
      lsel <= 4'h0;
    end else begin
      if (i_wr && i_addr == `TSRL_A_DUR) begin
        p_dur <= (i_wdata[15:0] == 16'h0) ? 16'h1 : i_wdata[15:0];
      end
      if (i_wr && i_addr == `TSRL_A_IVL) begin
        p_ivl <= i_wdata[15:0];
      end
      if (i_wr && i_addr == `TSRL_A_CFG) begin
        p_cfg <= i_wdata[15:0];
      end
      if (i_wr && i_addr == `TSRL_A_LSEL) begin
        lsel <= i_wdata[3:0];
      end
      if (c_commit) begin
        dur <= p_dur;
        ivl <= p_ivl;
        cfg <= p_cfg;
      end
    end
  end
  // Label characters are staged, then copied on apply.
  for (genvar g = 0; g < LL; g++) begin : g_label
    always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
        stage[g] <= 8'h0;
        label[g] <= 8'h0;
      end else begin
        if (wr_label && i_wdata[11:8] == 4'(g)) begin
          stage[g] <= i_wdata[7:0];
        end
        if (c_apply) begin
          label[g] <= stage[g];
        end
      end
    end
  end
  // An error counts unless its tally is full and not being cleared.
  wire ext_inc = i_ext_err && (wr_errs || ext_cnt != 16'hffff);
  wire int_inc = i_int_err && (wr_errs || int_cnt != 16'hffff);
  // Error tallies saturate; a write clears, a same-cycle error still counts.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ext_cnt <= 16'h0;
      int_cnt <= 16'h0;
    end else begin
      ext_cnt <= (wr_errs ? 16'h0 : ext_cnt) + {15'h0, ext_inc};
      int_cnt <= (wr_errs ? 16'h0 : int_cnt) + {15'h0, int_inc};
    end
  end
  // ****************************************************************
  // Result log and download
  // ****************************************************************
  // Every finished test is logged with its timestamp.
  tsrl_log #(.DEPTH(LOG_DEPTH), .W(80)) u_log (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_push(done),
    .i_rec({tod, next_tnum, i_result}),
    .i_erase(c_erase),
    .i_start(c_dlall || c_dlnew),
    .i_new_only(dl_new),
    .i_next(rd_ldata && log_valid && word == 2'h3),
    .o_rec(log_rec),
    .o_valid(log_valid),
    .o_count(log_cnt)
  );
  // Download mode and word position within a record.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      dl_new <= 1'b0;
      word <= 2'h0;
    end else begin
      if (c_dlall || c_dlnew) begin
        dl_new <= c_dlnew;
        word <= 2'h0;
      end else if (rd_ldata && log_valid) begin
        word <= word + 2'h1;
      end
    end
  end
  // ****************************************************************
  // Read port
  // ****************************************************************
  // Read selection; record words are serial, time, number, result.
  always_comb begin
    next_rdata = 32'h0;
    if (i_addr == `TSRL_A_STATUS) begin
      next_rdata = {27'h0, o_alarm, fault, 1'b0, state};
    end else if (i_addr == `TSRL_A_PROG) begin
      next_rdata = {22'h0, prog};
    end else if (i_addr == `TSRL_A_TNUM) begin
      next_rdata = {16'h0, tnum};
    end else if (i_addr == `TSRL_A_FLOW) begin
      next_rdata = {16'h0, flow};
    end else if (i_addr == `TSRL_A_ERRS) begin
      next_rdata = {int_cnt, ext_cnt};
    end else if (i_addr == `TSRL_A_DUR) begin
      next_rdata = {p_dur, dur};
    end else if (i_addr == `TSRL_A_CFG) begin
      next_rdata = {p_cfg, cfg};
    end else if (i_addr == `TSRL_A_IVL) begin
      next_rdata = {p_ivl, ivl};
    end else if (i_addr == `TSRL_A_TIME) begin
      next_rdata = tod;
    end else if (i_addr == `TSRL_A_LABEL) begin
      next_rdata = (lsel < 4'(LL)) ? {24'h0, label[lsel]} : 32'h0;
    end else if (i_addr == `TSRL_A_LCNT) begin
      next_rdata = {15'h0, log_valid, log_cnt};
    end else if (i_addr == `TSRL_A_LDATA && log_valid) begin
      next_rdata = (word == 2'h0) ? SERIAL_NUM :
                   (word == 2'h1) ? log_rec[79:48] :
                   (word == 2'h2) ? {16'h0, log_rec[47:32]} : log_rec[31:0];
    end
  end
  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? next_rdata : 32'h0;
    end
  end
  assign o_testing = (state == tsrl_pkg::ST_TEST);
  assign o_fault = fault;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_start;
    c_start && !c_stop;
  endsequence
  sequence s_fresh;
    prog == 10'h0 && el_s == 16'h0 && state == tsrl_pkg::ST_TEST;
  endsequence
  a_prog_bound: assert property (prog <= 10'h3e8)
    else $error("Progress above 1000.");
  a_start_fresh: assert property (s_start |=> s_fresh)
    else $error("Start did not begin a fresh test.");
  a_stop_ready: assert property (c_stop |=> state == tsrl_pkg::ST_READY ##1
    (!o_testing || $past(begin_test)))
    else $error("Stop did not abandon the test.");
  a_done_count: assert property (done |=> tnum == $past(tnum) + 16'h1 &&
    (prog == 10'h3e8 || $past(begin_test)))
    else $error("Finished test not counted.");
  a_fault_latch: assert property (done |=> o_fault == $past(low_flow))
    else $error("Fault not taken at test end.");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("Read data stood without a read.");
  a_erase_empty: assert property (c_erase && !done |=> log_cnt == 16'h0)
    else $error("Erase left records in the log.");
  a_flow_hold: assert property ($changed(flow) |-> $past(done))
    else $error("Flow changed outside test end.");
  a_commit_only: assert property ($changed(dur) || $changed(cfg) |-> $past(c_commit))
    else $error("Settings changed without commit.");
  a_time_load: assert property (wr_time |-> ##2 tod == $past(i_wdata, 2))
    else $error("Time set not loaded.");
  a_err_count: assert property (i_ext_err && !wr_errs && ext_cnt < 16'h10 |=>
    ext_cnt == $past(ext_cnt) + 16'h1)
    else $error("External error not counted.");
  a_repeat_go: assert property (done && repeat_now && !c_stop |=> s_fresh)
    else $error("Repeat did not restart at once.");
endmodule : tsrl_top

// ---- test/tsrl_host_model.sv ----
// Host computer model: register bus master of the test sequencer.
// Assumes one clock; every strobe changes just after a rising edge.
`timescale 1ns/100ps
`include "tsrl_map.svh"
module tsrl_host_model (
  input wire logic i_sys_clk, // System clock.
  input wire logic [31:0] i_rdata, // Read data.
  output logic [7:0] o_addr, // Register address.
  output logic [31:0] o_wdata, // Write data.
  output logic o_wr, // Write strobe.
  output logic o_rd // Read strobe.
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Bus starts idle.
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One write cycle; released data is inverted so it never looks held.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask : wr_reg
  // One read cycle; data is taken in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask : rd_reg
  // Label characters beyond the fifteenth are never sent.
  task automatic put_label(input logic [3:0] i, input logic [7:0] c);
    if (i < 4'(`TSRL_LABEL_LEN)) wr_reg(`TSRL_A_LABEL, {20'h0, i, c});
  endtask : put_label
endmodule : tsrl_host_model

// ---- test/tb_top.sv ----
// Self-checking bench of the test sequencer and result logger.
// Assumes a 10 MHz clock, ten cycles per tick and an eight-record log.
`timescale 1ns/100ps
`include "tsrl_map.svh"
module tb_top;
  logic clk, rst_n, wr, rd, fp, ee, ie, testing, alarm, fault;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, res, v;
  logic [15:0] rate;
  int mismatches, cmp_count, cyc, n, c;
  tsrl_top #(.TICK_CYCLES(10), .LOG_DEPTH(8)) u_tsrl_top (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_flow_present(fp),
    .i_flow_rate(rate), .i_result(res), .i_ext_err(ee), .i_int_err(ie), .o_testing(testing),
    .o_alarm(alarm), .o_fault(fault));
  tsrl_host_model u_tsrl_host_model (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_tsrl_host_model.wr_reg(a, d);
    #1;
  endtask : w
  task automatic r(input logic [7:0] a, output logic [31:0] d);
    u_tsrl_host_model.rd_reg(a, d);
  endtask : r
  task automatic cmd(input int b);
    w(`TSRL_A_CMD, 32'h1 << b);
  endtask : cmd
  // Waits for the running test to end; returns cycles waited.
  task automatic run_end(output int k);
    k = 0;
    while (testing !== 1'b0 && k < 300) begin
      @(posedge clk);
      #1 k++;
    end
    chk("testing", 1'b0, testing);
  endtask : run_end
  task automatic run();
    cmd(`TSRL_C_START);
    run_end(n);
  endtask : run
  task automatic setcfg(input logic [31:0] d);
    w(`TSRL_A_CFG, d);
    cmd(`TSRL_C_COMMIT);
  endtask : setcfg
  // Walks a download; returns the count and the first test number.
  task automatic dl(input int b, output int k, output logic [31:0] f);
    logic [31:0] s, t, q;
    k = 0;
    cmd(b);
    for (int j = 0; j < 30; j++) begin
      r(`TSRL_A_LCNT, s);
      if (s[16] === 1'b1) begin
        r(`TSRL_A_LDATA, s);
        r(`TSRL_A_LDATA, t);
        r(`TSRL_A_LDATA, q);
        r(`TSRL_A_LDATA, v);
        chk("serial", 32'h1, s);
        chk("stamp", 1'b1, t >= 32'h1000);
        if (k == 0) f = q;
        k++;
      end
    end
  endtask : dl
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_run();
    r(`TSRL_A_TNUM, v);
    chk("tnum rst", 0, v);
    w(`TSRL_A_DUR, 2);
    cmd(`TSRL_C_COMMIT);
    cmd(`TSRL_C_START);
    chk("testing", 1'b1, testing);
    r(`TSRL_A_PROG, v);
    chk("prog start", 0, v);
    @(posedge clk) rate <= 16'h0456;
    repeat (5) @(posedge clk);
    r(`TSRL_A_PROG, v);
    chk("prog mid", 1'b1, v > 0 && v < 1000);
    r(`TSRL_A_FLOW, v);
    chk("flow mid", 0, v);
    run_end(n);
    r(`TSRL_A_FLOW, v);
    chk("flow", 32'h456, v);
    r(`TSRL_A_PROG, v);
    chk("prog end", 1000, v);
    r(`TSRL_A_TNUM, v);
    chk("tnum", 1, v);
    $display("run done");
  endtask : t_run
  task automatic t_stop();
    cmd(`TSRL_C_START);
    repeat (5) @(posedge clk);
    cmd(`TSRL_C_STOP);
    chk("stopped", 1'b0, testing);
    repeat (30) @(posedge clk);
    r(`TSRL_A_TNUM, v);
    chk("tnum stop", 1, v);
    cmd(`TSRL_C_START);
    repeat (12) @(posedge clk);
    cmd(`TSRL_C_START);
    r(`TSRL_A_PROG, v);
    chk("prog restart", 0, v);
    run_end(n);
    chk("full length", 1'b1, n >= 10);
    r(`TSRL_A_TNUM, v);
    chk("tnum restart", 2, v);
    $display("stop done");
  endtask : t_stop
  task automatic t_misc();
    @(posedge clk) ee <= 1'b1;
    @(posedge clk) ee <= 1'b0;
    @(posedge clk) ee <= 1'b1;
    ie <= 1'b1;
    @(posedge clk) ee <= 1'b0;
    ie <= 1'b0;
    r(`TSRL_A_ERRS, v);
    chk("errs", 32'h0001_0002, v);
    w(`TSRL_A_ERRS, 0);
    r(`TSRL_A_ERRS, v);
    chk("errs clr", 0, v);
    w(`TSRL_A_TIME, 32'h1000);
    r(`TSRL_A_TIME, v);
    chk("time", 1'b1, v == 32'h1000 || v == 32'h1001);
    w(`TSRL_A_LSEL, 3);
    u_tsrl_host_model.put_label(4'h3, 8'h41);
    #1 r(`TSRL_A_LABEL, v);
    chk("label staged", 0, v);
    cmd(`TSRL_C_APPLY);
    r(`TSRL_A_LABEL, v);
    chk("label", 32'h41, v);
    $display("misc done");
  endtask : t_misc
  task automatic t_mode();
    @(posedge clk) fp <= 1'b0;
    repeat (3) @(posedge clk);
    run();
    chk("fault", 1'b1, fault);
    r(`TSRL_A_STATUS, v);
    chk("status", 32'h8, v & 32'hb);
    w(`TSRL_A_CFG, 32'h2);
    run();
    chk("uncommitted", 1'b1, fault);
    cmd(`TSRL_C_COMMIT);
    run();
    chk("simulate", 1'b0, fault);
    @(posedge clk) res <= 32'h0000_2000;
    for (int f = 0; f < 2; f++) begin
      setcfg(32'h1002 | (f << 2));
      run();
      chk("alarm", f, alarm);
    end
    w(`TSRL_A_IVL, 0);
    setcfg(32'h3);
    cmd(`TSRL_C_START);
    repeat (60) @(posedge clk);
    r(`TSRL_A_TNUM, v);
    chk("repeat", 1'b1, v >= 10 && testing === 1'b1);
    w(`TSRL_A_IVL, 4);
    cmd(`TSRL_C_COMMIT);
    run_end(n);
    r(`TSRL_A_STATUS, v);
    chk("waiting", 2, v & 32'h3);
    setcfg(32'h2);
    cmd(`TSRL_C_STOP);
    $display("mode done");
  endtask : t_mode
  task automatic t_log();
    logic [31:0] f, tn;
    cmd(`TSRL_C_ERASE);
    r(`TSRL_A_LCNT, v);
    chk("erased", 0, v & 32'hffff);
    repeat (9) run();
    r(`TSRL_A_LCNT, v);
    chk("held", 8, v & 32'hffff);
    r(`TSRL_A_TNUM, tn);
    dl(`TSRL_C_DLALL, c, f);
    chk("all count", 8, c);
    chk("oldest", tn - 7, f);
    dl(`TSRL_C_DLNEW, c, f);
    chk("new none", 0, c);
    run();
    dl(`TSRL_C_DLNEW, c, f);
    chk("new one", 1, c);
    chk("new num", tn + 1, f);
    dl(`TSRL_C_DLALL, c, f);
    chk("all again", 8, c);
    $display("log done");
  endtask : t_log
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    fp = 1'b1;
    ee = 1'b0;
    ie = 1'b0;
    rate = 16'h0123;
    res = 32'h0403_0201;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_run();
    t_stop();
    t_misc();
    t_mode();
    t_log();
    results();
  end
endmodule : tb_top
